// File: frsf_pkg.sv
package frsf_pkg;

    // Register map, word index on the plain register port
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ST1  = 4'h1;
    localparam logic [3:0] REG_ST2  = 4'h2;
    localparam logic [3:0] REG_ST3  = 4'h3;

    // Control register fields
    localparam int unsigned CTRL_US_LO = 0;
    localparam int unsigned CTRL_US_HI = 1;
    localparam int unsigned CTRL_SIDE  = 2;
    localparam logic [2:0]  CTRL_RESET = 3'h0;

    // Result status one fields
    localparam int unsigned ST1_ND = 2;
    localparam int unsigned ST1_NW = 1;
    localparam int unsigned ST1_MA = 0;

    // Result status two fields
    localparam int unsigned ST2_UNUSED = 7;
    localparam int unsigned ST2_CM     = 6;
    localparam int unsigned ST2_DD     = 5;
    localparam int unsigned ST2_WC     = 4;
    localparam int unsigned ST2_SH     = 3;
    localparam int unsigned ST2_SN     = 2;
    localparam int unsigned ST2_BC     = 1;
    localparam int unsigned ST2_MD     = 0;

    // Drive status three fields
    localparam int unsigned ST3_FT  = 7;
    localparam int unsigned ST3_WP  = 6;
    localparam int unsigned ST3_RDY = 5;
    localparam int unsigned ST3_T0  = 4;
    localparam int unsigned ST3_TS  = 3;
    localparam int unsigned ST3_HD  = 2;
    localparam int unsigned ST3_US1 = 1;
    localparam int unsigned ST3_US0 = 0;

    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Command codes on the command port
    localparam logic [2:0] CMD_READ      = 3'h0;
    localparam logic [2:0] CMD_WRITE     = 3'h1;
    localparam logic [2:0] CMD_WRITE_DEL = 3'h2;
    localparam logic [2:0] CMD_FORMAT    = 3'h3;
    localparam logic [2:0] CMD_SCAN      = 3'h4;
    localparam logic [2:0] CMD_READ_ID   = 3'h5;

    // Index passes allowed while hunting an ID mark
    localparam logic [1:0] INDEX_PASSES = 2'h2;
    localparam logic [7:0] CYL_ALL_ONES = 8'hFF;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_BUSY = 2'b10
    } frsf_phase_t;

    function automatic logic frsf_is_write(input logic [2:0] cmd);
        return (cmd == CMD_WRITE) || (cmd == CMD_WRITE_DEL) || (cmd == CMD_FORMAT);
    endfunction : frsf_is_write

    function automatic logic frsf_is_rd_scan(input logic [2:0] cmd);
        return (cmd == CMD_READ) || (cmd == CMD_SCAN);
    endfunction : frsf_is_rd_scan

    function automatic logic frsf_cyl_differs(input logic [7:0] a, input logic [7:0] b);
        return a != b;
    endfunction : frsf_cyl_differs

endpackage : frsf_pkg

// File: frsf_sync.sv
`timescale 1ns/1ps
module frsf_sync #(
    parameter int unsigned W = 6
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Pin levels in and out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule : frsf_sync

// File: frsf_index_count.sv
`timescale 1ns/1ps
module frsf_index_count (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Search control
    input  wire logic i_search,
    input  wire logic i_found,
    input  wire logic i_index_edge,
    // Two passes seen without a mark
    output logic      o_missing
);

    logic [1:0] passes;
    logic [1:0] next_passes;
    logic       next_missing;

    always_comb begin
        next_passes  = passes;
        next_missing = 1'b0;
        if (!i_search || i_found) begin
            next_passes = 2'h0;
        end else if (i_index_edge) begin
            if (passes + 2'h1 == frsf_pkg::INDEX_PASSES) begin
                next_missing = 1'b1;
                next_passes  = 2'h0;
            end else begin
                next_passes = passes + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            passes    <= 2'h0;
            o_missing <= 1'b0;
        end else begin
            passes    <= next_passes;
            o_missing <= next_missing;
        end
    end

endmodule : frsf_index_count

// File: frsf_status.sv
// Functional notes
// - Write-protect during write commands sets blocked flag
// - No ID mark after two index passes
// - Missing data mark sets both mark flags
// - Result status two bit seven reads zero
// - Deleted mark seen during read or scan
// - Data field CRC failure sets flag
// - Cylinder mismatch accompanies sector not found
// - Scan equality condition met sets flag
// - Scan found no satisfying sector
// - All-ones mismatching cylinder flags bad cylinder
// - Read without data mark sets flag
// - Drive status shows fault input level
// - Drive status shows write-protect input level
// - Drive status shows ready input level
// - Drive status shows track-zero input level
// - Drive status shows double-sided input level
// - Drive status shows driven side select
// - Drive status shows driven unit selects
// - Missing sector during read, scan or write-deleted sets sector-not-found flag
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module frsf_status (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,

    // Register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,

    // Command sequencing from the controller core
    input  wire logic       i_cmd_start,
    input  wire logic [2:0] i_cmd_code,
    input  wire logic       i_cmd_end,

    // Events from the controller core
    input  wire logic       i_id_search,
    input  wire logic       i_id_found,
    input  wire logic       i_data_mark_miss,
    input  wire logic       i_deleted_mark,
    input  wire logic       i_data_crc_err,
    input  wire logic       i_sector_miss,
    input  wire logic [7:0] i_cyl_read,
    input  wire logic [7:0] i_cyl_req,
    input  wire logic       i_scan_equal,
    input  wire logic       i_scan_unmet,

    // Drive sense pins
    input  wire logic       i_drive_fault_level,
    input  wire logic       i_write_protect_level,
    input  wire logic       i_ready_level,
    input  wire logic       i_track_zero_level,
    input  wire logic       i_double_sided_level,
    input  wire logic       i_index_level,

    // Drive select pins
    output logic            o_unit_select_low,
    output logic            o_unit_select_high,
    output logic            o_side_select_level,

    // Command phase
    output logic            o_busy
);

    // Synchronised pin levels
    logic [5:0] pins_sync;
    logic       fault_s;
    logic       wp_s;
    logic       rdy_s;
    logic       t0_s;
    logic       ts_s;
    logic       index_s;
    logic       index_prev;
    logic       index_edge;
    logic       id_missing;

    // Command phase state
    frsf_pkg::frsf_phase_t phase;
    frsf_pkg::frsf_phase_t next_phase;
    logic [2:0]  cmd;
    logic [2:0]  next_cmd;

    // Flags of the running command
    logic write_blocked_flag;
    logic address_mark_absent_flag;
    logic sector_not_found_flag;
    logic deleted_mark_seen_flag;
    logic data_field_crc_flag;
    logic cylinder_mismatch_flag;
    logic scan_equal_flag;
    logic scan_unmet_flag;
    logic bad_cylinder_flag;
    logic data_mark_absent_flag;
    logic next_write_blocked_flag;
    logic next_address_mark_absent_flag;
    logic next_sector_not_found_flag;
    logic next_deleted_mark_seen_flag;
    logic next_data_field_crc_flag;
    logic next_cylinder_mismatch_flag;
    logic next_scan_equal_flag;
    logic next_scan_unmet_flag;
    logic next_bad_cylinder_flag;
    logic next_data_mark_absent_flag;

    // Reported result bytes
    logic [7:0] result_status_one;
    logic [7:0] result_status_two;
    logic [7:0] next_result_status_one;
    logic [7:0] next_result_status_two;
    logic [7:0] drive_status_three;

    // Register port state
    logic [2:0] ctrl;
    logic [2:0] next_ctrl;
    logic [7:0] next_rdata;

    logic       running;
    logic       cyl_diff;

    frsf_sync #(
        .W (6)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_index_level, i_double_sided_level, i_track_zero_level,
                   i_ready_level, i_write_protect_level, i_drive_fault_level}),
        .o_sync  (pins_sync)
    );

    assign fault_s = pins_sync[0];
    assign wp_s    = pins_sync[1];
    assign rdy_s   = pins_sync[2];
    assign t0_s    = pins_sync[3];
    assign ts_s    = pins_sync[4];
    assign index_s = pins_sync[5];

    // Edge taken on synchronised level only
    assign index_edge = index_s && !index_prev;

    frsf_index_count u_index (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_search     (i_id_search && running),
        .i_found      (i_id_found),
        .i_index_edge (index_edge),
        .o_missing    (id_missing)
    );

    // Command phase
    always_comb begin
        next_phase = phase;
        next_cmd   = cmd;
        case (phase)
            frsf_pkg::PH_IDLE: begin
                if (i_cmd_start) begin
                    next_phase = frsf_pkg::PH_BUSY;
                    next_cmd   = i_cmd_code;
                end
            end
            frsf_pkg::PH_BUSY: begin
                if (i_cmd_start) begin
                    next_cmd = i_cmd_code;
                end else if (i_cmd_end) begin
                    next_phase = frsf_pkg::PH_IDLE;
                end
            end
            default: begin
                next_phase = frsf_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase      <= frsf_pkg::PH_IDLE;
            cmd        <= frsf_pkg::CMD_READ;
            index_prev <= 1'b0;
        end else begin
            phase      <= next_phase;
            cmd        <= next_cmd;
            index_prev <= index_s;
        end
    end

    assign running  = (phase == frsf_pkg::PH_BUSY);
    assign cyl_diff = frsf_pkg::frsf_cyl_differs(i_cyl_read, i_cyl_req);

    // Running flags; an event in the start cycle survives the clear only while a command is already running
    always_comb begin
        next_write_blocked_flag       = write_blocked_flag;
        next_address_mark_absent_flag = address_mark_absent_flag;
        next_sector_not_found_flag    = sector_not_found_flag;
        next_deleted_mark_seen_flag   = deleted_mark_seen_flag;
        next_data_field_crc_flag      = data_field_crc_flag;
        next_cylinder_mismatch_flag   = cylinder_mismatch_flag;
        next_scan_equal_flag          = scan_equal_flag;
        next_scan_unmet_flag          = scan_unmet_flag;
        next_bad_cylinder_flag        = bad_cylinder_flag;
        next_data_mark_absent_flag    = data_mark_absent_flag;
        if (i_cmd_start) begin
            next_write_blocked_flag       = 1'b0;
            next_address_mark_absent_flag = 1'b0;
            next_sector_not_found_flag    = 1'b0;
            next_deleted_mark_seen_flag   = 1'b0;
            next_data_field_crc_flag      = 1'b0;
            next_cylinder_mismatch_flag   = 1'b0;
            next_scan_equal_flag          = 1'b0;
            next_scan_unmet_flag          = 1'b0;
            next_bad_cylinder_flag        = 1'b0;
            next_data_mark_absent_flag    = 1'b0;
        end
        if (running) begin
            if (frsf_pkg::frsf_is_write(cmd) && wp_s) begin
                next_write_blocked_flag = 1'b1;
            end
            if (id_missing) begin
                next_address_mark_absent_flag = 1'b1;
            end
            if (i_data_mark_miss) begin
                next_address_mark_absent_flag = 1'b1;
                next_data_mark_absent_flag    = 1'b1;
            end
            if (i_deleted_mark && frsf_pkg::frsf_is_rd_scan(cmd)) begin
                next_deleted_mark_seen_flag = 1'b1;
            end
            if (i_data_crc_err) begin
                next_data_field_crc_flag = 1'b1;
            end
            if (i_sector_miss && (frsf_pkg::frsf_is_rd_scan(cmd) || cmd == frsf_pkg::CMD_WRITE_DEL)) begin
                next_sector_not_found_flag = 1'b1;
                if (cyl_diff) begin
                    next_cylinder_mismatch_flag = 1'b1;
                end
                if (cyl_diff && i_cyl_read == frsf_pkg::CYL_ALL_ONES) begin
                    next_bad_cylinder_flag = 1'b1;
                end
            end
            if (cmd == frsf_pkg::CMD_SCAN && i_scan_equal) begin
                next_scan_equal_flag = 1'b1;
            end
            if (cmd == frsf_pkg::CMD_SCAN && i_scan_unmet) begin
                next_scan_unmet_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            write_blocked_flag       <= 1'b0;
            address_mark_absent_flag <= 1'b0;
            sector_not_found_flag    <= 1'b0;
            deleted_mark_seen_flag   <= 1'b0;
            data_field_crc_flag      <= 1'b0;
            cylinder_mismatch_flag   <= 1'b0;
            scan_equal_flag          <= 1'b0;
            scan_unmet_flag          <= 1'b0;
            bad_cylinder_flag        <= 1'b0;
            data_mark_absent_flag    <= 1'b0;
        end else begin
            write_blocked_flag       <= next_write_blocked_flag;
            address_mark_absent_flag <= next_address_mark_absent_flag;
            sector_not_found_flag    <= next_sector_not_found_flag;
            deleted_mark_seen_flag   <= next_deleted_mark_seen_flag;
            data_field_crc_flag      <= next_data_field_crc_flag;
            cylinder_mismatch_flag   <= next_cylinder_mismatch_flag;
            scan_equal_flag          <= next_scan_equal_flag;
            scan_unmet_flag          <= next_scan_unmet_flag;
            bad_cylinder_flag        <= next_bad_cylinder_flag;
            data_mark_absent_flag    <= next_data_mark_absent_flag;
        end
    end

    // Report holds the last finished command until the next one ends
    always_comb begin
        next_result_status_one = result_status_one;
        next_result_status_two = result_status_two;
        if (running && i_cmd_end && !i_cmd_start) begin
            next_result_status_one                       = frsf_pkg::STATUS_RESET;
            next_result_status_one[frsf_pkg::ST1_ND]     = sector_not_found_flag;
            next_result_status_one[frsf_pkg::ST1_NW]     = write_blocked_flag;
            next_result_status_one[frsf_pkg::ST1_MA]     = address_mark_absent_flag;
            next_result_status_two                       = frsf_pkg::STATUS_RESET;
            next_result_status_two[frsf_pkg::ST2_UNUSED] = 1'b0;
            next_result_status_two[frsf_pkg::ST2_CM]     = deleted_mark_seen_flag;
            next_result_status_two[frsf_pkg::ST2_DD]     = data_field_crc_flag;
            next_result_status_two[frsf_pkg::ST2_WC]     = cylinder_mismatch_flag;
            next_result_status_two[frsf_pkg::ST2_SH]     = scan_equal_flag;
            next_result_status_two[frsf_pkg::ST2_SN]     = scan_unmet_flag;
            next_result_status_two[frsf_pkg::ST2_BC]     = bad_cylinder_flag;
            next_result_status_two[frsf_pkg::ST2_MD]     = data_mark_absent_flag;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            result_status_one <= frsf_pkg::STATUS_RESET;
            result_status_two <= frsf_pkg::STATUS_RESET;
        end else begin
            result_status_one <= next_result_status_one;
            result_status_two <= next_result_status_two;
        end
    end

    // Live drive byte; select bits come from the registered outputs
    always_comb begin
        drive_status_three                     = frsf_pkg::STATUS_RESET;
        drive_status_three[frsf_pkg::ST3_FT]  = fault_s;
        drive_status_three[frsf_pkg::ST3_WP]  = wp_s;
        drive_status_three[frsf_pkg::ST3_RDY] = rdy_s;
        drive_status_three[frsf_pkg::ST3_T0]  = t0_s;
        drive_status_three[frsf_pkg::ST3_TS]  = ts_s;
        drive_status_three[frsf_pkg::ST3_HD]  = o_side_select_level;
        drive_status_three[frsf_pkg::ST3_US1] = o_unit_select_high;
        drive_status_three[frsf_pkg::ST3_US0] = o_unit_select_low;
    end

    // Register port; unmapped reads return zero
    always_comb begin
        next_ctrl  = ctrl;
        next_rdata = frsf_pkg::STATUS_RESET;
        if (i_wr && i_addr == frsf_pkg::REG_CTRL) begin
            next_ctrl = i_wdata[2:0];
        end
        if (i_rd) begin
            case (i_addr)
                frsf_pkg::REG_CTRL: next_rdata = {5'h00, ctrl};
                frsf_pkg::REG_ST1:  next_rdata = result_status_one;
                frsf_pkg::REG_ST2:  next_rdata = result_status_two;
                frsf_pkg::REG_ST3:  next_rdata = drive_status_three;
                default:            next_rdata = frsf_pkg::STATUS_RESET;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl                <= frsf_pkg::CTRL_RESET;
            o_rdata             <= frsf_pkg::STATUS_RESET;
            o_unit_select_low   <= 1'b0;
            o_unit_select_high  <= 1'b0;
            o_side_select_level <= 1'b0;
            o_busy              <= 1'b0;
        end else begin
            ctrl                <= next_ctrl;
            o_rdata             <= next_rdata;
            o_unit_select_low   <= next_ctrl[frsf_pkg::CTRL_US_LO];
            o_unit_select_high  <= next_ctrl[frsf_pkg::CTRL_US_HI];
            o_side_select_level <= next_ctrl[frsf_pkg::CTRL_SIDE];
            o_busy              <= (next_phase == frsf_pkg::PH_BUSY);
        end
    end

endmodule : frsf_status

// File: frsf_status_props.sv
`timescale 1ns/1ps
module frsf_status_props (
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Command sequencing
    input wire logic       i_cmd_start,
    input wire logic       i_cmd_end,
    // Drive pins
    input wire logic       i_drive_fault_level,
    input wire logic       i_write_protect_level,
    input wire logic       i_ready_level,
    input wire logic       i_track_zero_level,
    input wire logic       i_double_sided_level,
    input wire logic       o_unit_select_low,
    input wire logic       o_unit_select_high,
    input wire logic       o_side_select_level,
    input wire logic       o_busy
);
    logic [4:0] pins;
    assign pins = {i_drive_fault_level, i_write_protect_level, i_ready_level,
                   i_track_zero_level, i_double_sided_level};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Status two flags imply their partners in status one or two; top bit of status two reads zero
    sequence st2_then_st1(int b);
        i_rd && i_addr == frsf_pkg::REG_ST2 && !i_cmd_start && !i_cmd_end
        ##1 o_rdata[b] && i_rd && i_addr == frsf_pkg::REG_ST1 && !i_cmd_start;
    endsequence

    a_mark_both: assert property (st2_then_st1(0) |=> o_rdata[0])
        else $error("mark flags unpaired");
    a_cyl_needs_nf: assert property (st2_then_st1(4) |=> o_rdata[2])
        else $error("cyl flag unpaired");
    a_bad_cyl_pair: assert property (i_rd && i_addr == frsf_pkg::REG_ST2 |=> !o_rdata[1] || o_rdata[4])
        else $error("bad cyl unpaired");
    a_st2_top_zero: assert property (i_rd && i_addr == frsf_pkg::REG_ST2 |=> !o_rdata[7])
        else $error("status two top bit set");
    // Sync stages settle after reset
    a_pins_mirror: assert property (i_rd && i_addr == frsf_pkg::REG_ST3 && !$past(i_rst) && !$past(i_rst, 2)
        && $stable(pins) && pins == $past(pins, 2) |=> o_rdata[7:3] == $past(pins))
        else $error("pins mismatch");
    a_sel_mirror: assert property (i_rd && i_addr == frsf_pkg::REG_ST3 |=> o_rdata[2:0] ==
        {$past(o_side_select_level), $past(o_unit_select_high), $past(o_unit_select_low)})
        else $error("selects mismatch");
    a_ctrl_drive: assert property (i_wr && i_addr == frsf_pkg::REG_CTRL |=>
        {o_side_select_level, o_unit_select_high, o_unit_select_low} == $past(i_wdata[2:0]))
        else $error("selects not written");
    a_start_busy: assert property (i_cmd_start |=> o_busy)
        else $error("busy not raised by start");
    a_end_idle: assert property (o_busy && i_cmd_end && !i_cmd_start |=> !o_busy)
        else $error("busy not dropped by end");
endmodule : frsf_status_props

bind frsf_status frsf_status_props props_u (.*);

// File: frsf_drive_model.sv
`timescale 1ns/1ps
module frsf_drive_model (
    // Clock for pin timing
    input  wire logic       i_clk,
    // Sense pins: fault, protect, ready, track zero, two sides
    output logic      [4:0] o_levels,
    output logic            o_index_level
);
    // Short revolution keeps runs brief
    localparam int IDX_HI = 4;
    localparam int IDX_LO = 6;

    initial begin
        o_levels      = 5'h00;
        o_index_level = 1'b0;
    end

    task automatic set_levels(input logic [4:0] v);
        @(posedge i_clk);
        o_levels <= v;
    endtask : set_levels

    // Index low between spins
    task automatic spin(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_index_level <= 1'b1;
            repeat (IDX_HI) @(posedge i_clk);
            o_index_level <= 1'b0;
            repeat (IDX_LO) @(posedge i_clk);
        end
    endtask : spin
endmodule : frsf_drive_model

// File: frsf_status_tb.sv
`timescale 1ns/1ps
module frsf_status_tb;
    logic       i_clk       = 1'b0;
    logic       i_rst       = 1'b1;
    logic [3:0] i_addr      = 4'h0;
    logic [7:0] i_wdata     = 8'h00;
    logic       i_wr        = 1'b0;
    logic       i_rd        = 1'b0;
    logic       i_cmd_start = 1'b0;
    logic [2:0] i_cmd_code  = 3'h0;
    logic       i_cmd_end   = 1'b0;
    logic       i_id_search = 1'b0;
    logic [5:0] ev          = 6'h00;
    logic [7:0] i_cyl_read  = 8'h00;
    logic [7:0] i_cyl_req   = 8'h00;
    logic [7:0] o_rdata;
    logic [4:0] lv;
    logic       idx;
    int         err_count   = 0;
    int         tests_run   = 0;

    always #12.5 i_clk = ~i_clk;

    frsf_drive_model drv_u (.i_clk(i_clk), .o_levels(lv), .o_index_level(idx));

    frsf_status dut_u (
        .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_cmd_start, .i_cmd_code, .i_cmd_end,
        .i_id_search, .i_id_found(1'b0), .i_data_mark_miss(ev[0]), .i_deleted_mark(ev[1]),
        .i_data_crc_err(ev[2]), .i_sector_miss(ev[3]), .i_cyl_read, .i_cyl_req,
        .i_scan_equal(ev[4]), .i_scan_unmet(ev[5]), .i_drive_fault_level(lv[4]),
        .i_write_protect_level(lv[3]), .i_ready_level(lv[2]), .i_track_zero_level(lv[1]),
        .i_double_sided_level(lv[0]), .i_index_level(idx), .o_unit_select_low(),
        .o_unit_select_high(), .o_side_select_level(), .o_busy()
    );

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic rd21(output logic [7:0] s1, output logic [7:0] s2);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= frsf_pkg::REG_ST2;
        @(posedge i_clk);
        i_addr <= frsf_pkg::REG_ST1;
        #1 s2 = o_rdata;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 s1 = o_rdata;
    endtask : rd21

    task automatic run(input logic [2:0] c, input logic [5:0] e, input logic [7:0] cr, input logic [7:0] cq,
                       input int nidx, input logic [7:0] e1, input logic [7:0] e2);
        logic [7:0] s1, s2;
        @(posedge i_clk);
        i_cmd_start <= 1'b1;
        i_cmd_code  <= c;
        i_cyl_read  <= cr;
        i_cyl_req   <= cq;
        @(posedge i_clk);
        i_cmd_start <= 1'b0;
        i_id_search <= (nidx > 0);
        drv_u.spin(nidx);
        repeat (4) @(posedge i_clk);
        i_id_search <= 1'b0;
        ev          <= e;
        @(posedge i_clk);
        ev <= 6'h00;
        @(posedge i_clk);
        i_cmd_end <= 1'b1;
        @(posedge i_clk);
        i_cmd_end <= 1'b0;
        rd21(s1, s2);
        chk("status one", e1, s1);
        chk("status two", e2, s2);
    endtask : run

    task automatic t_regs;
        logic [7:0] d;
        rd(frsf_pkg::REG_CTRL, d);
        chk("control", 8'h00, d);
        rd(4'h9, d);
        chk("unmapped", 8'h00, d);
        wr(frsf_pkg::REG_CTRL, 8'h05);
        rd(frsf_pkg::REG_ST3, d);
        chk("drive status three", 8'h05, d);
        wr(frsf_pkg::REG_CTRL, 8'h02);
        wr(frsf_pkg::REG_ST1, 8'hFF);
        rd(frsf_pkg::REG_ST3, d);
        chk("drive status three", 8'h02, d);
        rd(frsf_pkg::REG_ST1, d);
        chk("status one", 8'h00, d);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_pins;
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            drv_u.set_levels(5'h01 << i);
            repeat (3) @(posedge i_clk);
            rd(frsf_pkg::REG_ST3, d);
            chk("drive status three", {5'h01 << i, 3'h2}, d);
        end
        drv_u.set_levels(5'h00);
        $display("t_pins done");
    endtask : t_pins

    task automatic t_protect;
        drv_u.set_levels(5'h08);
        for (logic [2:0] c = 3'h1; c <= 3'h3; c++) begin
            run(c, 6'h00, 8'h00, 8'h00, 0, 8'h02, 8'h00);
        end
        run(frsf_pkg::CMD_READ, 6'h00, 8'h00, 8'h00, 0, 8'h00, 8'h00);
        drv_u.set_levels(5'h00);
        $display("t_protect done");
    endtask : t_protect

    task automatic t_flags;
        logic [7:0] s1, s2;
        run(frsf_pkg::CMD_SCAN, 6'h10, 8'h00, 8'h00, 0, 8'h00, 8'h08);
        run(frsf_pkg::CMD_SCAN, 6'h20, 8'h00, 8'h00, 0, 8'h00, 8'h04);
        run(frsf_pkg::CMD_READ, 6'h02, 8'h00, 8'h00, 0, 8'h00, 8'h40);
        run(frsf_pkg::CMD_WRITE, 6'h02, 8'h00, 8'h00, 0, 8'h00, 8'h00);
        run(frsf_pkg::CMD_READ, 6'h04, 8'h00, 8'h00, 0, 8'h00, 8'h20);
        run(frsf_pkg::CMD_READ, 6'h01, 8'h00, 8'h00, 0, 8'h01, 8'h01);
        run(frsf_pkg::CMD_READ, 6'h08, 8'h03, 8'h03, 0, 8'h04, 8'h00);
        run(frsf_pkg::CMD_WRITE_DEL, 6'h08, 8'h05, 8'h03, 0, 8'h04, 8'h10);
        run(frsf_pkg::CMD_SCAN, 6'h08, 8'hFF, 8'h03, 0, 8'h04, 8'h12);
        run(frsf_pkg::CMD_READ, 6'h08, 8'hFF, 8'hFF, 0, 8'h04, 8'h00);
        run(frsf_pkg::CMD_READ_ID, 6'h00, 8'h00, 8'h00, 0, 8'h00, 8'h00);
        // Idle events leave report alone
        @(posedge i_clk);
        ev <= 6'h04;
        @(posedge i_clk);
        ev <= 6'h00;
        rd21(s1, s2);
        chk("status two", 8'h00, s2);
        $display("t_flags done");
    endtask : t_flags

    task automatic t_index;
        run(frsf_pkg::CMD_READ_ID, 6'h00, 8'h00, 8'h00, 2, 8'h01, 8'h00);
        run(frsf_pkg::CMD_READ_ID, 6'h00, 8'h00, 8'h00, 1, 8'h00, 8'h00);
        $display("t_index done");
    endtask : t_index

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_pins();
        t_protect();
        t_flags();
        t_index();
        give_verdict();
    end

    // Far beyond the run length
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        give_verdict();
    end
endmodule : frsf_status_tb
